// ==== hw/router_fault_and_cam_test.sv ====
`timescale 1ns/1ns
`default_nettype none
// Contract
// - A disabled associative entry never matches.
// - Blocked output link is bypassed by emergency routing.
// - Per-link divert of default multicast to monitor.
// - Per-link discard of default multicast, no stall.
// - Detect parity, phase, length and unroutable faults.
// - One write loads every CAM location together.
// - CAM space reads answer with bus error.
// - No match sets the miss bit to 1.
// - Lowest matching entry reported in entry field.
// - Router RAMs are readable and writable.
// - Divert code 00 normal, x1 monitor, 10 discard.
// - Result holds entry in 10:1, miss in 0.
module router_fault_and_cam_test
   import rfct_pkg::*;
(
   input  wire logic                         clk,
   input  wire logic                         rst,
   // Register port.
   input  wire logic                         regSel,
   input  wire logic                         regWrite,
   input  wire logic [rfct_pkg::ADDR_W-1:0]  regAddr,
   input  wire logic [31:0]                  regWdata,
   output logic      [31:0]                  regRdata,
   output logic                              regAck,
   output logic                              regErr,
   // Incoming multicast packets.
   input  wire logic                         pktValid,
   output logic                              pktReady,
   input  wire logic [rfct_pkg::HDR_W-1:0]   pktHdr,
   input  wire logic [rfct_pkg::KEY_W-1:0]   pktKey,
   input  wire logic [2:0]                   pktSrc,
   input  wire logic                         pktLocal,
   input  wire logic [rfct_pkg::LEN_W-1:0]   pktLen,
   input  wire logic [rfct_pkg::NUM_LINKS-1:0] linkBlocked,
   // Routed packets.
   output logic                              outValid,
   input  wire logic                         outReady,
   output logic      [rfct_pkg::KEY_W-1:0]   outKey,
   output logic      [rfct_pkg::VEC_W-1:0]   outVector,
   output logic                              outEmergency
);
   import rfct_pkg::*;

   // ------------------------------------------------------------------------
   // Storage and control registers.
   // ------------------------------------------------------------------------
   logic [KEY_W-1:0] camKey   [CAM_ENTRIES];   // Ternary CAM values.
   logic [KEY_W-1:0] camMask  [CAM_ENTRIES];   // Ternary CAM care bits.
   logic [31:0]      routeRam [CAM_ENTRIES];   // Vector plus disable bit.
   logic [11:0]      divert_ff;                // Two bits per link.
   logic [3:0]       errStat_ff;               // Sticky fault flags.
   logic [KEY_W-1:0] lookupKey_ff;             // Test lookup key.
   logic [KEY_W-1:0] parKey_ff;                // Parallel write value.
   logic [KEY_W-1:0] parMask_ff;               // Parallel write mask.
   logic [1:0]       phase_ff;                 // Current time phase.
   logic [31:0]      regRdata_ff;
   logic             regAck_ff;
   logic             regErr_ff;
   logic [11:0]      nxt_divert;
   logic [3:0]       nxt_errStat;
   logic [KEY_W-1:0] nxt_lookupKey;
   logic [KEY_W-1:0] nxt_parKey;
   logic [KEY_W-1:0] nxt_parMask;
   logic [1:0]       nxt_phase;
   logic [31:0]      nxt_regRdata;
   logic             nxt_regAck;
   logic             nxt_regErr;

   // Decoded bus request.
   logic [1:0]       region;
   logic [IDX_W-1:0] index;
   logic             wrStrobe;
   logic             rdStrobe;
   logic             parWrite;

   // Packet path.
   logic [IDX_W:0]   pktLook;
   logic [IDX_W:0]   testLook;
   rfct_dest_t       dest;
   logic [1:0]       divCode;
   logic [VEC_W-1:0] baseVec;
   logic [VEC_W-1:0] finalVec;
   logic [NUM_LINKS-1:0] blockedHit;
   logic             emergency;
   logic [3:0]       pktFault;
   logic             dropPkt;
   logic             fifoInReady;
   logic             accept;

   // ------------------------------------------------------------------------
   // Associative lookup, shared by the packet path and the test path.
   // ------------------------------------------------------------------------
   // Returns {miss, index}. Scanning downwards leaves the lowest hit.
   function automatic logic [IDX_W:0] camLookup(input logic [KEY_W-1:0] key);
      logic [IDX_W:0] res;
      res = {1'b1, {IDX_W{1'b0}}};
      for (int i = CAM_ENTRIES - 1; i >= 0; i--) begin
         if (!routeRam[i][ROUTE_DIS_BIT] &&
             ((key & camMask[i]) == camKey[i])) begin
            res = {1'b0, IDX_W'(i)};
         end
      end
      return res;
   endfunction

   // ------------------------------------------------------------------------
   // Packet classification and routing.
   // ------------------------------------------------------------------------
   assign pktLook  = camLookup(pktKey);
   assign testLook = camLookup(lookupKey_ff);
   assign divCode  = (pktSrc < 3'(NUM_LINKS)) ? divert_ff[2*pktSrc +: 2] : DIV_NORMAL;

   always_comb begin
      // Fault checks: odd parity, phase current or previous, exact length.
      pktFault              = '0;
      pktFault[ERR_PARITY]  = ~(^{pktHdr, pktKey});
      pktFault[ERR_PHASE]   = (pktHdr[PHASE_LSB +: 2] != phase_ff) &&
                              (pktHdr[PHASE_LSB +: 2] != phase_ff - 2'h1);
      pktFault[ERR_LENGTH]  = pktLen != (pktHdr[PAYLOAD_BIT] ? LEN_LONG : LEN_SHORT);
      // A miss on a default path picks its fate from the divert field.
      if (!pktLook[IDX_W]) begin
         dest = DEST_ROUTED;
      end else if (pktLocal) begin
         dest = DEST_DROP;
         pktFault[ERR_UNROUTE] = 1'b1;
      end else if (divCode[0]) begin
         dest = DEST_MONITOR;
      end else if (divCode == DIV_DISCARD) begin
         dest = DEST_DROP;
      end else begin
         dest = DEST_DEFAULT;
      end
      baseVec = '0;
      unique case (dest)
         DEST_ROUTED: begin
            baseVec = routeRam[pktLook[IDX_W-1:0]][VEC_W-1:0];
         end
         DEST_DEFAULT: begin
            // Default routing continues straight across the chip.
            baseVec[(int'(pktSrc) + 3) % NUM_LINKS] = 1'b1;
         end
         DEST_MONITOR: begin
            baseVec[MONITOR_BIT] = 1'b1;
         end
         DEST_DROP: begin
            baseVec = '0;
         end
      endcase
      // A blocked link is steered to its neighbour rather than waited on.
      blockedHit = baseVec[NUM_LINKS-1:0] & linkBlocked;
      emergency  = |blockedHit;
      finalVec   = baseVec;
      finalVec[NUM_LINKS-1:0] = (baseVec[NUM_LINKS-1:0] & ~linkBlocked) |
                                {blockedHit[NUM_LINKS-2:0], blockedHit[NUM_LINKS-1]};
   end

   // Dropped packets are consumed at once, so they never hold the input.
   assign dropPkt  = (|pktFault) || (dest == DEST_DROP);
   assign pktReady = dropPkt || fifoInReady;
   assign accept   = pktValid && pktReady;

   rfct_fifo #(
      .WIDTH (OUT_W),
      .DEPTH (FIFO_DEPTH)
   ) u_outFifo (
      .clk      (clk),
      .rst      (rst),
      .inValid  (pktValid && !dropPkt),
      .inReady  (fifoInReady),
      .inData   ({emergency, finalVec, pktKey}),
      .outValid (outValid),
      .outReady (outReady),
      .outData  ({outEmergency, outVector, outKey})
   );

   // ------------------------------------------------------------------------
   // Register port decode and next values.
   // ------------------------------------------------------------------------
   assign region   = regAddr[REGION_LSB +: 2];
   assign index    = regAddr[INDEX_LSB +: IDX_W];
   assign wrStrobe = regSel && regWrite;
   assign rdStrobe = regSel && !regWrite;
   assign parWrite = wrStrobe && (region == REG_REGION) && (regAddr == OFF_PCMD);

   always_comb begin
      nxt_divert    = divert_ff;
      nxt_lookupKey = lookupKey_ff;
      nxt_parKey    = parKey_ff;
      nxt_parMask   = parMask_ff;
      nxt_phase     = phase_ff;
      nxt_errStat   = errStat_ff;
      nxt_regRdata  = '0;
      nxt_regAck    = regSel;
      nxt_regErr    = 1'b0;
      // Software clears with ones; a fault in the same cycle still sets.
      if (wrStrobe && regAddr == OFF_ERRSTAT) begin
         nxt_errStat = errStat_ff & ~regWdata[3:0];
      end
      if (accept) begin
         nxt_errStat = nxt_errStat | pktFault;
      end
      if (wrStrobe && region == REG_REGION) begin
         unique case (regAddr)
            OFF_DIVERT: nxt_divert    = regWdata[11:0];
            OFF_LKEY:   nxt_lookupKey = regWdata;
            OFF_PKEY:   nxt_parKey    = regWdata;
            OFF_PMASK:  nxt_parMask   = regWdata;
            OFF_CTRL:   nxt_phase     = regWdata[1:0];
            default: begin
               // Other offsets take no write.
            end
         endcase
      end
      if (rdStrobe) begin
         unique case (region)
            REG_REGION: begin
               unique case (regAddr)
                  OFF_DIVERT:  nxt_regRdata = {20'h00000, divert_ff};
                  OFF_ERRSTAT: nxt_regRdata = {28'h0000000, errStat_ff};
                  OFF_LKEY:    nxt_regRdata = lookupKey_ff;
                  OFF_LRES: begin
                     // Entry bits carry no meaning while the miss bit is set.
                     nxt_regRdata = {21'h000000, testLook[IDX_W-1:0],
                                     testLook[IDX_W]};
                  end
                  OFF_PKEY:    nxt_regRdata = parKey_ff;
                  OFF_PMASK:   nxt_regRdata = parMask_ff;
                  OFF_CTRL:    nxt_regRdata = {30'h00000000, phase_ff};
                  default:     nxt_regRdata = '0;
               endcase
            end
            ROUTE_REGION: begin
               nxt_regRdata = routeRam[index];
            end
            default: begin
               // The CAM has no read port; only association tests it.
               nxt_regErr = 1'b1;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // Register update.
   // ------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         divert_ff    <= DIVERT_RST;
         errStat_ff   <= ERR_RST;
         lookupKey_ff <= '0;
         parKey_ff    <= '0;
         parMask_ff   <= '0;
         phase_ff     <= PHASE_RST;
         regRdata_ff  <= '0;
         regAck_ff    <= 1'b0;
         regErr_ff    <= 1'b0;
      end else begin
         divert_ff    <= nxt_divert;
         errStat_ff   <= nxt_errStat;
         lookupKey_ff <= nxt_lookupKey;
         parKey_ff    <= nxt_parKey;
         parMask_ff   <= nxt_parMask;
         phase_ff     <= nxt_phase;
         regRdata_ff  <= nxt_regRdata;
         regAck_ff    <= nxt_regAck;
         regErr_ff    <= nxt_regErr;
      end
   end

   // Router memories; all entries come out of reset disabled so that
   // uninitialised CAM contents can never produce a spurious match.
   always_ff @(posedge clk) begin
      for (int i = 0; i < CAM_ENTRIES; i++) begin
         if (rst) begin
            routeRam[i] <= ROUTE_RST;
         end else if (wrStrobe && region == ROUTE_REGION && index == IDX_W'(i)) begin
            routeRam[i] <= regWdata;
         end
         if (parWrite) begin
            camKey[i]  <= parKey_ff;
            camMask[i] <= parMask_ff;
         end else if (wrStrobe && index == IDX_W'(i)) begin
            if (region == KEY_REGION) begin
               camKey[i] <= regWdata;
            end
            if (region == MASK_REGION) begin
               camMask[i] <= regWdata;
            end
         end
      end
   end

   assign regRdata = regRdata_ff;
   assign regAck   = regAck_ff;
   assign regErr   = regErr_ff;
endmodule
`default_nettype wire

// ==== hw/rfct_pkg.sv ====
`default_nettype none
// ----------------------------------------------------------------------------
// Shared constants for the router fault-handling and CAM test block.
// ----------------------------------------------------------------------------
package rfct_pkg;
   // Sizes of the associative router and the packet path.
   localparam int unsigned CAM_ENTRIES = 1024;           // Associative entries.
   localparam int unsigned IDX_W       = 10;             // Entry index width.
   localparam int unsigned KEY_W       = 32;             // Routing key width.
   localparam int unsigned VEC_W       = 24;             // Links plus processors.
   localparam int unsigned NUM_LINKS   = 6;              // Inter-chip links.
   localparam int unsigned HDR_W       = 8;              // Packet header width.
   localparam int unsigned LEN_W       = 7;              // Packet length field.
   localparam int unsigned ADDR_W      = 16;             // Register address width.
   localparam int unsigned FIFO_DEPTH  = 8;              // Output buffer depth.
   localparam int unsigned OUT_W       = KEY_W + VEC_W + 1;
   localparam int unsigned MONITOR_BIT = 6;              // Vector bit of the monitor.

   // Register offsets (byte addresses).
   localparam logic [ADDR_W-1:0] OFF_DIVERT  = 16'h0000;
   localparam logic [ADDR_W-1:0] OFF_ERRSTAT = 16'h0004;
   localparam logic [ADDR_W-1:0] OFF_LKEY    = 16'h0008;
   localparam logic [ADDR_W-1:0] OFF_LRES    = 16'h000c;
   localparam logic [ADDR_W-1:0] OFF_PKEY    = 16'h0010;
   localparam logic [ADDR_W-1:0] OFF_PMASK   = 16'h0014;
   localparam logic [ADDR_W-1:0] OFF_PCMD    = 16'h0018;
   localparam logic [ADDR_W-1:0] OFF_CTRL    = 16'h001c;

   // Memory regions, selected by the top two address bits.
   localparam logic [1:0] REG_REGION   = 2'h0;
   localparam logic [1:0] KEY_REGION   = 2'h1;
   localparam logic [1:0] MASK_REGION  = 2'h2;
   localparam logic [1:0] ROUTE_REGION = 2'h3;
   localparam int unsigned REGION_LSB  = 14;
   localparam int unsigned INDEX_LSB   = 2;

   // Field positions.
   localparam int unsigned RES_MISS_BIT  = 0;
   localparam int unsigned RES_ENTRY_LSB = 1;
   localparam int unsigned ROUTE_DIS_BIT = 31;
   localparam int unsigned ERR_PARITY    = 0;
   localparam int unsigned ERR_PHASE     = 1;
   localparam int unsigned ERR_LENGTH    = 2;
   localparam int unsigned ERR_UNROUTE   = 3;
   localparam int unsigned PAYLOAD_BIT   = 1;
   localparam int unsigned PHASE_LSB     = 6;

   // Divert field codes, two bits per incoming link.
   localparam logic [1:0] DIV_NORMAL  = 2'h0;
   localparam logic [1:0] DIV_DISCARD = 2'h2;

   // Reset values.
   localparam logic [11:0] DIVERT_RST = 12'h000;
   localparam logic [3:0]  ERR_RST    = 4'h0;
   localparam logic [1:0]  PHASE_RST  = 2'h0;
   localparam logic [31:0] ROUTE_RST  = 32'h8000_0000;   // Entry disabled.

   // Expected packet lengths in bits.
   localparam logic [LEN_W-1:0] LEN_SHORT = 7'h28;       // 40 bits.
   localparam logic [LEN_W-1:0] LEN_LONG  = 7'h48;       // 72 bits.

   // Destination chosen for an accepted packet.
   typedef enum logic [1:0] {
      DEST_ROUTED  = 2'b00,
      DEST_DEFAULT = 2'b01,
      DEST_MONITOR = 2'b10,
      DEST_DROP    = 2'b11
   } rfct_dest_t;
endpackage
`default_nettype wire

// ==== hw/rfct_fifo.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------------
// Output buffer with valid/ready on both sides.
// ----------------------------------------------------------------------------
module rfct_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];     // Storage flip-flops.
   logic [AW-1:0]    wrPtr_ff;        // Next slot to fill.
   logic [AW-1:0]    rdPtr_ff;        // Oldest slot.
   logic [AW:0]      count_ff;        // Words held.
   logic [AW-1:0]    nxt_wrPtr;
   logic [AW-1:0]    nxt_rdPtr;
   logic [AW:0]      nxt_count;
   logic             push;
   logic             pop;

   // ------------------------------------------------------------------------
   // Flags and pointer arithmetic.
   // ------------------------------------------------------------------------
   assign inReady  = (count_ff != DEPTH[AW:0]);
   assign outValid = (count_ff != '0);
   assign outData  = mem[rdPtr_ff];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   // Pointers wrap at DEPTH so a non-power-of-two depth also works.
   always_comb begin
      nxt_wrPtr = wrPtr_ff;
      nxt_rdPtr = rdPtr_ff;
      nxt_count = count_ff;
      if (push) begin
         nxt_wrPtr = (wrPtr_ff == AW'(DEPTH - 1)) ? '0 : wrPtr_ff + 1'b1;
      end
      if (pop) begin
         nxt_rdPtr = (rdPtr_ff == AW'(DEPTH - 1)) ? '0 : rdPtr_ff + 1'b1;
      end
      if (push && !pop) begin
         nxt_count = count_ff + 1'b1;
      end else if (pop && !push) begin
         nxt_count = count_ff - 1'b1;
      end
   end

   // Registers; the storage itself needs no reset.
   always_ff @(posedge clk) begin
      if (rst) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
      end else begin
         wrPtr_ff <= nxt_wrPtr;
         rdPtr_ff <= nxt_rdPtr;
         count_ff <= nxt_count;
      end
      if (push) begin
         mem[wrPtr_ff] <= inData;
      end
   end
endmodule
`default_nettype wire

// ==== tb/rfct_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------
// Port-level checks of the register answer and the routed packet stream.
// ----------------
module rfct_checker
   import rfct_pkg::*;
(
   input wire logic                        clk,
   input wire logic                        rst,
   input wire logic                        regSel,
   input wire logic                        regWrite,
   input wire logic [rfct_pkg::ADDR_W-1:0] regAddr,
   input wire logic [31:0]                 regRdata,
   input wire logic                        regAck,
   input wire logic                        regErr,
   input wire logic                        pktValid,
   input wire logic                        pktReady,
   input wire logic                        outValid,
   input wire logic                        outReady,
   input wire logic [rfct_pkg::KEY_W-1:0]  outKey,
   input wire logic [rfct_pkg::VEC_W-1:0]  outVector,
   input wire logic                        outEmergency
);
   // One clock domain, so clocking and reset are given once.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_ack_next: assert property (regSel |=> regAck)
      else $error("request not answered next cycle");
   chk_ack_cause: assert property (!regSel |=> !regAck && regRdata == 32'h0)
      else $error("answer or data without a request");
   chk_cam_rderr: assert property (regSel && !regWrite && (regAddr[15:14] == KEY_REGION || regAddr[15:14] == MASK_REGION) |=> regErr && regRdata == 32'h0)
      else $error("associative array read not refused");
   chk_ok_noerr: assert property (regSel && (regWrite || regAddr[15] == regAddr[14]) |=> !regErr)
      else $error("bus error on a legal access");
   chk_res_fmt: assert property (regSel && !regWrite && regAddr == OFF_LRES |=> regRdata[31:11] == 21'h0)
      else $error("lookup result upper bits not clear");
   chk_miss_entry: assert property (regSel && !regWrite && regAddr == OFF_LRES ##1 regRdata[0] |-> regRdata[10:1] == 10'h0)
      else $error("miss result carries an entry");
   chk_out_hold: assert property (outValid && !outReady |=> outValid && $stable(outKey) && $stable(outVector) && $stable(outEmergency))
      else $error("output word changed while stalled");
   chk_ready_empty: assert property (!outValid |-> pktReady)
      else $error("input refused with empty buffer");

   // Main scenarios worth seeing at least once.
   cover property (regSel && regWrite && regAddr == OFF_LKEY ##1 regSel && !regWrite && regAddr == OFF_LRES);
   cover property (regErr);
   cover property (pktValid && !pktReady);
   cover property (outValid && outReady && outEmergency);
endmodule
`default_nettype wire

// ==== tb/rfct_sink.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------
// Downstream consumer: takes words promptly, slowly or not at all.
// ----------------
module rfct_sink (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic stall,
   input  wire logic slow,
   output logic      outReady
);
   logic [7:0] lfsr_ff;   // Own pattern, so stalls do not follow the bench's draws.

   // Ready moves only at the falling edge, clear of the sampling edge.
   always @(negedge clk) begin
      if (rst) lfsr_ff <= 8'h5a;
      else lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
      outReady <= !rst && !stall && (!slow || lfsr_ff[0]);
   end
endmodule
`default_nettype wire

// ==== tb/router_fault_and_cam_test_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module router_fault_and_cam_test_tb;
   import rfct_pkg::*;
   logic        clk, rst, regSel, regWrite, regAck, regErr, stall, slow;
   logic        pktValid, pktReady, pktLocal, outValid, outReady, outEmergency;
   logic [15:0] regAddr;
   logic [31:0] regWdata, regRdata, pktKey, outKey, seed, rd, keyA, keyB;
   logic [23:0] outVector, vecB;
   logic [7:0]  pktHdr;
   logic [6:0]  pktLen;
   logic [5:0]  linkBlocked;
   logic [2:0]  pktSrc;
   logic [56:0] expQ[$];   // Expected {emergency, vector, key} in order.
   int          n_mismatch, compares, cycles, s, waits;

   router_fault_and_cam_test uut (.clk(clk), .rst(rst), .regSel(regSel), .regWrite(regWrite),
      .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck),
      .regErr(regErr), .pktValid(pktValid), .pktReady(pktReady), .pktHdr(pktHdr),
      .pktKey(pktKey), .pktSrc(pktSrc), .pktLocal(pktLocal), .pktLen(pktLen),
      .linkBlocked(linkBlocked), .outValid(outValid), .outReady(outReady), .outKey(outKey),
      .outVector(outVector), .outEmergency(outEmergency));
   rfct_sink sink (.clk(clk), .rst(rst), .stall(stall), .slow(slow), .outReady(outReady));

   // ----------------
   // Helpers
   // ----------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [15:0] ra(logic [1:0] r, int i);
      return {r, 2'h0, 10'(i), 2'h0};
   endfunction

   // Blocked link bits step to the next link; any step flags emergency.
   function automatic logic [24:0] route(logic [23:0] v, logic [5:0] b);
      logic [5:0] l;
      l = v[5:0] & ~b;
      for (int i = 0; i < 6; i++) if (v[i] && b[i]) l[(i + 1) % 6] = 1'b1;
      return {|(v[5:0] & b), v[23:6], l};
   endfunction

   task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic complete_run();
      if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Request is left standing so that accesses can run back to back.
   task automatic bus(logic w, logic [15:0] a, logic [31:0] d, logic e);
      regSel = 1'b1;
      regWrite = w;
      regAddr = a;
      regWdata = d;
      @(negedge clk);
      rd = regRdata;
      chk("ack err", {regAck, regErr}, {1'b1, e});
   endtask

   task automatic rdc(logic [15:0] a, logic [31:0] e, logic err);
      bus(1'b0, a, 32'h0, err);
      chk("rdata", rd, e);
   endtask

   task automatic look(logic [31:0] k, logic [31:0] e);
      bus(1'b1, OFF_LKEY, k, 1'b0);
      rdc(OFF_LRES, e, 1'b0);
   endtask

   task automatic idle();
      regSel = 1'b0;
      @(negedge clk);
   endtask

   task automatic pidle();
      pktValid = 1'b0;
      @(negedge clk);
   endtask

   // Bad: 1 flips parity, 2 spoils the length. Valid stays up after the take.
   task automatic send(logic [31:0] k, int src, logic loc, logic [1:0] ph, int bad);
      logic [7:0] h;
      h = {ph, 4'h0, k[0], 1'b0};
      h[0] = ~^{h, k} ^ (bad == 1);
      {pktKey, pktSrc, pktLocal, pktValid, pktHdr} = {k, 3'(src), loc, 1'b1, h};
      pktLen = (k[0] ? LEN_LONG : LEN_SHORT) + 7'(bad == 2);
      for (int t = 0; t < 200; t++) begin
         #4;
         waits = t;
         if (pktReady === 1'b1) break;
         @(negedge clk);
      end
      @(negedge clk);
   endtask

   task automatic drain();
      for (int t = 0; t < 300 && expQ.size() > 0; t++) @(negedge clk);
      chk("left in queue", expQ.size(), 0);
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Output monitor and hang limit.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         complete_run();
      end else if (!rst && outValid === 1'b1 && outReady === 1'b1) begin
         if (expQ.size() == 0) chk("unexpected out", 1, 0);
         else chk("out word", {outEmergency, outVector, outKey}, expQ.pop_front());
      end
   end

   // ----------------
   // Main sequence
   // ----------------
   initial begin
      seed = 32'hc7797470;
      {rst, slow} = 2'b11;
      {regSel, regWrite, regAddr, regWdata, stall} = '0;
      {pktValid, pktKey, pktHdr, pktSrc, pktLocal, pktLen, linkBlocked} = '0;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      rdc(OFF_DIVERT, 32'h0, 1'b0);
      rdc(OFF_ERRSTAT, 32'h0, 1'b0);
      rdc(ra(ROUTE_REGION, 7), ROUTE_RST, 1'b0);
      rdc(16'h0020, 32'h0, 1'b0);
      for (int i = 0; i < 4; i++) begin
         s = int'(rnd() % 32'd1024);
         keyA = (rnd() & 32'h00ff_ffff) | ROUTE_RST;
         bus(1'b1, ra(ROUTE_REGION, s), keyA, 1'b0);
         rdc(ra(ROUTE_REGION, s), keyA, 1'b0);
         bus(1'b1, ra(KEY_REGION, s), keyA, 1'b0);
         rdc(ra(KEY_REGION, s), 32'h0, 1'b1);
         rdc(ra(MASK_REGION, s), 32'h0, 1'b1);
      end
      keyA = rnd();
      vecB = 24'(rnd());
      bus(1'b1, OFF_PKEY, keyA, 1'b0);
      bus(1'b1, OFF_PMASK, 32'hffff_ffff, 1'b0);
      bus(1'b1, OFF_PCMD, 32'h0, 1'b0);
      bus(1'b1, ra(ROUTE_REGION, 9), {8'h00, vecB}, 1'b0);
      bus(1'b1, ra(ROUTE_REGION, 5), 32'h0, 1'b0);
      look(keyA, 32'h0000_000a);
      bus(1'b1, ra(ROUTE_REGION, 5), ROUTE_RST, 1'b0);
      look(keyA, 32'h0000_0012);
      look(keyA ^ (32'h1 << (rnd() % 32)), 32'h1);
      keyB = ~keyA;
      bus(1'b1, ra(KEY_REGION, 9), keyB, 1'b0);
      look(keyA, 32'h1);
      look(keyB, 32'h0000_0012);
      for (int c = 0; c < 4; c++) begin
         s = int'(rnd() % 6);
         bus(1'b1, OFF_DIVERT, 32'(c) << (2 * s), 1'b0);
         idle();
         if (c == 0) expQ.push_back({1'b0, 24'h1 << ((s + 3) % 6), keyA});
         if (c % 2 == 1) expQ.push_back({1'b0, 24'h40, keyA});
         send(keyA, s, 1'b0, 2'h0, 0);
         pidle();
      end
      drain();
      bus(1'b1, OFF_CTRL, 32'h1, 1'b0);
      rdc(OFF_CTRL, 32'h1, 1'b0);
      rdc(OFF_ERRSTAT, 32'h0, 1'b0);
      for (int f = 0; f < 4; f++) begin
         send(keyA, 0, f == 3, (f == 1) ? 2'h2 : 2'h0, (f == 0) ? 1 : ((f == 2) ? 2 : 0));
         pidle();
         rdc(OFF_ERRSTAT, 32'h1 << f, 1'b0);
         bus(1'b1, OFF_ERRSTAT, 32'hf, 1'b0);
         rdc(OFF_ERRSTAT, 32'h0, 1'b0);
         idle();
      end
      bus(1'b1, OFF_DIVERT, 32'h0000_0aaa, 1'b0);
      idle();
      #2;
      stall = 1'b1;
      @(negedge clk);
      for (int i = 0; i < 8; i++) begin
         linkBlocked = 6'(rnd());
         expQ.push_back({route(vecB, linkBlocked), keyB});
         send(keyB, 0, 1'b0, 2'h0, 0);
      end
      send(keyA, 1, 1'b0, 2'h0, 0);
      chk("drop waits", waits, 0);
      expQ.push_back({route(vecB, linkBlocked), keyB});
      fork
         send(keyB, 2, 1'b0, 2'h0, 0);
         begin
            repeat (3) @(negedge clk);
            #4;
            chk("full ready", pktReady, 0);
            stall = 1'b0;
         end
      join
      pidle();
      drain();
      rdc(OFF_ERRSTAT, 32'h0, 1'b0);
      complete_run();
   end
endmodule

bind router_fault_and_cam_test rfct_checker chk (.clk(clk), .rst(rst), .regSel(regSel),
   .regWrite(regWrite), .regAddr(regAddr), .regRdata(regRdata), .regAck(regAck),
   .regErr(regErr), .pktValid(pktValid), .pktReady(pktReady), .outValid(outValid),
   .outReady(outReady), .outKey(outKey), .outVector(outVector), .outEmergency(outEmergency));
`default_nettype wire
